/* modem_lines_pkg.sv */
// Purpose: Shared constants for the modem handshake line controller.
// Assumes: 100 MHz module clock, APB register access with 32-bit data.
// Notes:   Line levels are V.24 style: ON is low, OFF is high.
package modem_lines_pkg;

   // Clock and time base
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned MS_IN_NS = 1000000;
   localparam int unsigned CYC_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
   localparam int unsigned MS_CNT_W = 13;

   // Durations in milliseconds
   localparam logic [12:0] WAKE_TIME_MS = 13'h0014;
   localparam logic [12:0] RI_ON_MS = 13'h03E8;
   localparam logic [12:0] RI_OFF_MS = 13'h0FA0;
   localparam logic [12:0] SMS_ON_MS = 13'h03E8;

   // Most characters the device may still send after the host stops it
   localparam int unsigned STOP_CHARS_MAX = 2;

   // Register byte addresses
   localparam logic [7:0] CONFIG_ADDR = 8'h00;
   localparam logic [7:0] CONTROL_ADDR = 8'h04;
   localparam logic [7:0] EVENT_ADDR = 8'h08;
   localparam logic [7:0] STATUS_ADDR = 8'h0C;

   // Configuration field positions
   localparam int unsigned CFG_HW_FLOW = 0;
   localparam int unsigned CFG_DSR_OPT = 1;
   localparam int unsigned CFG_DCD_OPT = 2;
   localparam int unsigned CFG_SMS_EN = 3;
   localparam int unsigned CFG_PSAVE_LO = 4;
   localparam int unsigned CFG_MUX = 6;
   localparam int unsigned CFG_DTR_OPT = 7;
   localparam logic [7:0] CONFIG_RESET = 8'h07;

   // Control field positions
   localparam int unsigned CTL_DATA_MODE = 0;
   localparam int unsigned CTL_CARRIER = 1;
   localparam int unsigned CTL_VOICE = 2;
   localparam int unsigned CTL_PROMPT = 3;
   localparam int unsigned CTL_INCOMING = 4;
   localparam int unsigned CTL_PORT_READY = 5;
   localparam int unsigned CTL_AWAKE = 6;
   localparam logic [6:0] CONTROL_RESET = 7'h20;

   // Event field positions (write-one pulses)
   localparam int unsigned EV_SMS = 0;
   localparam int unsigned EV_ANSWER = 1;
   localparam int unsigned EV_DIAL_PKT = 2;
   localparam int unsigned EV_ACCEPT = 3;

   // Power saving modes
   localparam logic [1:0] PSAVE_OFF = 2'h0;
   localparam logic [1:0] PSAVE_CYCLIC = 2'h1;
   localparam logic [1:0] PSAVE_RTS = 2'h2;

   // Ring indicator sequencer states
   typedef enum logic [3:0] {
      RI_IDLE = 4'b0001,
      RI_CALL_ON = 4'b0010,
      RI_CALL_OFF = 4'b0100,
      RI_SMS = 4'b1000
   } ri_state_t;

endpackage

/* ms_timer_if.sv */
// Purpose: Carrier between the line controller and a millisecond timer.
// Assumes: One clock domain.
// Notes:   Load is a one-cycle pulse; expired is a one-cycle pulse.
`timescale 1ns/1ps
interface ms_timer_if;
   import modem_lines_pkg::*;
   logic load;
   logic [MS_CNT_W-1:0] load_ms;
   logic busy;
   logic expired;
   modport ctrl (output load, output load_ms, input busy, input expired);
   modport timer (input load, input load_ms, output busy, output expired);
endinterface

/* ms_timer.sv */
// Purpose: Millisecond countdown timer with its own clock divider.
// Assumes: CYC_PER_MS of at least 2.
// Notes:   A load restarts the divider, so a period is never cut short.
`timescale 1ns/1ps
module ms_timer
   import modem_lines_pkg::*;
#(
   parameter int unsigned CYCLES_PER_MS = CYC_PER_MS
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Control side
   ms_timer_if.timer tmr
);
   localparam int unsigned DW = $clog2(CYCLES_PER_MS);
   localparam logic [DW-1:0] DIV_LAST = DW'(CYCLES_PER_MS - 1);

   logic [DW-1:0] div_reg;
   logic [MS_CNT_W-1:0] ms_reg;
   logic busy_reg;
   logic exp_reg;
   wire ms_tick = busy_reg && (div_reg == DIV_LAST);

   assign tmr.busy = busy_reg;
   assign tmr.expired = exp_reg;

   // Divider makes a one-cycle millisecond enable, counter counts them down
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_reg <= '0;
         ms_reg <= '0;
         busy_reg <= 1'b0;
         exp_reg <= 1'b0;
      end else if (tmr.load) begin
         div_reg <= '0;
         ms_reg <= tmr.load_ms;
         busy_reg <= (tmr.load_ms != '0);
         exp_reg <= 1'b0;
      end else begin
         exp_reg <= ms_tick && (ms_reg == MS_CNT_W'(1));
         div_reg <= ms_tick ? '0 : (busy_reg ? div_reg + DW'(1) : div_reg);
         if (ms_tick) begin
            ms_reg <= ms_reg - MS_CNT_W'(1);
            busy_reg <= (ms_reg != MS_CNT_W'(1));
         end
      end
   end
endmodule

/* modem_lines.sv */
// Purpose: Modem-side handshake lines of a V.24 serial port (DCE end).
// Assumes: Host pins already synchronous to clk_i; framing lives elsewhere.
// Notes:   Reset release counts as port initialization.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps

module modem_lines
   import modem_lines_pkg::*;
#(
   parameter int unsigned CYCLES_PER_MS = CYC_PER_MS
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Host-facing lines (low means ON)
   input wire logic txd_i,
   input wire logic rts_n_i,
   input wire logic dtr_n_i,
   output logic rxd_o,
   output logic cts_n_o,
   output logic dsr_n_o,
   output logic dcd_n_o,
   output logic ri_n_o,
   output logic pullup_en_o,
   // Character transmitter side
   input wire logic tx_char_active_i,
   input wire logic tx_bit_i,
   output logic tx_grant_o,
   // Power and call state
   output logic port_en_o,
   output logic active_mode_o,
   output logic connect_o
);

   // Registers
   logic [7:0] cfg_reg;
   logic [6:0] ctl_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic rxd_reg;
   logic cts_n_reg;
   logic dsr_n_reg;
   logic dcd_n_reg;
   logic ri_n_reg;
   logic pullup_reg;
   logic grant_reg;
   logic port_en_reg;
   logic port_en_next;
   logic active_reg;
   logic connect_reg;
   logic connect_pend_reg;
   logic rts_on_reg;
   logic dtr_on_reg;
   logic wake_done_reg;
   ri_state_t ri_state_reg;
   ri_state_t ri_state_next;

   // Timer carriers
   ms_timer_if wake_tmr ();
   ms_timer_if ri_tmr ();

   // Wake-up and ring timers, counted from the module clock
   ms_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) wake_timer (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .tmr(wake_tmr.timer)
   );
   ms_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) ri_timer (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .tmr(ri_tmr.timer)
   );

   // Configuration fields
   wire hw_flow = cfg_reg[CFG_HW_FLOW];
   wire dsr_opt = cfg_reg[CFG_DSR_OPT];
   wire dcd_opt = cfg_reg[CFG_DCD_OPT];
   wire sms_en = cfg_reg[CFG_SMS_EN];
   wire [1:0] psave = cfg_reg[CFG_PSAVE_LO +: 2];
   wire mux_on = cfg_reg[CFG_MUX];
   wire dtr_opt = cfg_reg[CFG_DTR_OPT];

   // Host pins: undriven lines read high through the pad pull-up
   wire rts_on = !rts_n_i;
   wire dtr_on = !dtr_n_i;
   wire rts_rise_on = rts_on && !rts_on_reg;
   wire dtr_drop = dtr_on_reg && !dtr_on;

   // APB decode
   wire apb_setup = psel_i && !penable_i;
   wire apb_access = psel_i && penable_i && pready_reg;
   wire wr_cfg = apb_access && pwrite_i && !pslverr_reg && (paddr_i == CONFIG_ADDR);
   wire wr_ctl = apb_access && pwrite_i && (paddr_i == CONTROL_ADDR);
   wire wr_ev = apb_access && pwrite_i && (paddr_i == EVENT_ADDR);
   wire [1:0] new_psave = pwdata_i[CFG_PSAVE_LO +: 2];
   // A config that pairs flow control with RTS power saving is refused
   wire cfg_conflict = (new_psave == PSAVE_RTS) && pwdata_i[CFG_HW_FLOW];
   wire addr_ok = (paddr_i == CONFIG_ADDR) || (paddr_i == CONTROL_ADDR) ||
                  (paddr_i == EVENT_ADDR) || (paddr_i == STATUS_ADDR);
   wire err_setup = !addr_ok || (pwrite_i && (paddr_i == CONFIG_ADDR) && cfg_conflict) ||
                    (pwrite_i && (paddr_i == STATUS_ADDR));

   // Event pulses written by software
   wire ev_sms = wr_ev && pwdata_i[EV_SMS];
   wire ev_answer = wr_ev && pwdata_i[EV_ANSWER];
   wire ev_dial = wr_ev && pwdata_i[EV_DIAL_PKT];
   wire ev_accept = wr_ev && pwdata_i[EV_ACCEPT];

   // Status word
   wire [31:0] status_word = {20'h00000, txd_i, !ri_n_reg, !dsr_n_reg, !dcd_n_reg,
                              !cts_n_reg, active_reg, wake_done_reg, grant_reg,
                              port_en_reg, dtr_on_reg, rts_on_reg, !ctl_reg[CTL_PORT_READY]};

   // Read data selection
   wire [31:0] rd_word = (paddr_i == CONFIG_ADDR) ? {24'h000000, cfg_reg} :
                         (paddr_i == CONTROL_ADDR) ? {25'h0000000, ctl_reg} :
                         (paddr_i == STATUS_ADDR) ? status_word : 32'h00000000;

   // APB answer: setup cycle prepares, access cycle completes with no wait
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else begin
         pready_reg <= apb_setup;
         pslverr_reg <= apb_setup && err_setup;
         if (apb_setup) begin
            prdata_reg <= pwrite_i ? 32'h00000000 : rd_word;
         end
      end
   end

   // Configuration register, conflicting writes leave it untouched
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_reg <= CONFIG_RESET;
      end else if (wr_cfg) begin
         cfg_reg <= pwdata_i[7:0];
      end
   end

   // Control state: dial and accept event sets win over a DTR-drop clear in the same cycle
   logic [6:0] ctl_next;
   always_comb begin
      ctl_next = wr_ctl ? pwdata_i[6:0] : ctl_reg;
      if (ev_answer) begin
         ctl_next[CTL_INCOMING] = 1'b0;
      end
      if (dtr_drop && dtr_opt) begin
         ctl_next[CTL_DATA_MODE] = 1'b0;
      end
      if (ev_dial) begin
         ctl_next[CTL_DATA_MODE] = 1'b1;
      end
      if (ev_accept) begin
         ctl_next[CTL_CARRIER] = 1'b1;
         ctl_next[CTL_DATA_MODE] = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctl_reg <= CONTROL_RESET;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   // Power saving: port enable and active mode per saving mode
   wire rts_mode = (psave == PSAVE_RTS) && !hw_flow;
   always_comb begin
      if (psave == PSAVE_OFF) begin
         port_en_next = 1'b1;
      end else if (rts_mode) begin
         port_en_next = rts_on;
      end else begin
         port_en_next = ctl_reg[CTL_AWAKE];
      end
   end

   // Wake timer starts on every OFF-to-ON edge in RTS mode
   assign wake_tmr.load = rts_mode && rts_rise_on;
   assign wake_tmr.load_ms = WAKE_TIME_MS;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rts_on_reg <= 1'b0;
         dtr_on_reg <= 1'b0;
         port_en_reg <= 1'b1;
         active_reg <= 1'b1;
         wake_done_reg <= 1'b1;
      end else begin
         rts_on_reg <= rts_on;
         dtr_on_reg <= dtr_on;
         port_en_reg <= port_en_next;
         // Idle allowed only when port is off and software is not awake
         active_reg <= port_en_next || ctl_reg[CTL_AWAKE];
         if (wake_tmr.load) begin
            wake_done_reg <= 1'b0;
         end else if (wake_tmr.expired || !rts_mode) begin
            wake_done_reg <= 1'b1;
         end
      end
   end

   // Clear-to-send: mux mode shows power state, flow control shows readiness, else held ON
   wire cts_on_next = mux_on ? port_en_next :
                      hw_flow ? (port_en_next && ctl_reg[CTL_PORT_READY]) : 1'b1;

   // Transmit permission; a started character completes, so at most one
   // more character leaves after RTS goes OFF, inside the limit of two
   wire grant_next = hw_flow ? rts_on : 1'b1;

   // Data-set-ready and carrier-detect
   wire dsr_on_next = dsr_opt ? ctl_reg[CTL_DATA_MODE] : 1'b1;
   wire dcd_on_next = !dcd_opt ? 1'b1 :
                      (ctl_reg[CTL_CARRIER] || ctl_reg[CTL_VOICE] ||
                       ctl_reg[CTL_PROMPT] || ctl_reg[CTL_DATA_MODE]);

   // Ring indicator sequencer
   wire incoming = ctl_reg[CTL_INCOMING];
   wire sms_trig = ev_sms && sms_en;
   always_comb begin
      ri_state_next = ri_state_reg;
      ri_tmr.load = 1'b0;
      ri_tmr.load_ms = RI_ON_MS;
      case (ri_state_reg)
         RI_IDLE: begin
            if (sms_trig) begin
               ri_state_next = RI_SMS;
               ri_tmr.load = 1'b1;
               ri_tmr.load_ms = SMS_ON_MS;
            end else if (incoming) begin
               ri_state_next = RI_CALL_ON;
               ri_tmr.load = 1'b1;
            end
         end
         RI_CALL_ON: begin
            if (!incoming) begin
               ri_state_next = RI_IDLE;
            end else if (ri_tmr.expired) begin
               ri_state_next = RI_CALL_OFF;
               ri_tmr.load = 1'b1;
               ri_tmr.load_ms = RI_OFF_MS;
            end
         end
         RI_CALL_OFF: begin
            if (sms_trig) begin
               ri_state_next = RI_SMS;
               ri_tmr.load = 1'b1;
               ri_tmr.load_ms = SMS_ON_MS;
            end else if (!incoming) begin
               ri_state_next = RI_IDLE;
            end else if (ri_tmr.expired) begin
               ri_state_next = RI_CALL_ON;
               ri_tmr.load = 1'b1;
            end
         end
         RI_SMS: begin
            if (sms_trig) begin
               ri_tmr.load = 1'b1;
               ri_tmr.load_ms = SMS_ON_MS;
            end else if (ri_tmr.expired) begin
               ri_state_next = incoming ? RI_CALL_OFF : RI_IDLE;
               ri_tmr.load = incoming;
               ri_tmr.load_ms = RI_OFF_MS;
            end
         end
         default: begin
            ri_state_next = RI_IDLE;
         end
      endcase
   end
   wire ri_on_next = (ri_state_next == RI_CALL_ON) || (ri_state_next == RI_SMS);

   // Line outputs, all registered and at initial levels in reset
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ri_state_reg <= RI_IDLE;
         rxd_reg <= 1'b1;
         cts_n_reg <= 1'b0;
         dsr_n_reg <= 1'b1;
         dcd_n_reg <= 1'b1;
         ri_n_reg <= 1'b1;
         pullup_reg <= 1'b0;
         grant_reg <= 1'b1;
      end else begin
         ri_state_reg <= ri_state_next;
         rxd_reg <= tx_char_active_i ? tx_bit_i : 1'b1;
         cts_n_reg <= !cts_on_next;
         dsr_n_reg <= !dsr_on_next;
         dcd_n_reg <= !dcd_on_next;
         ri_n_reg <= !ri_on_next;
         pullup_reg <= 1'b1;
         grant_reg <= grant_next;
      end
   end

   // Connect result follows carrier-detect going ON
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         connect_pend_reg <= 1'b0;
         connect_reg <= 1'b0;
      end else begin
         connect_reg <= connect_pend_reg && !dcd_n_reg;
         if (ev_dial || ev_accept) begin
            connect_pend_reg <= 1'b1;
         end else if (!dcd_n_reg) begin
            connect_pend_reg <= 1'b0;
         end
      end
   end

   // Outputs
   assign prdata_o = prdata_reg;
   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign rxd_o = rxd_reg;
   assign cts_n_o = cts_n_reg;
   assign dsr_n_o = dsr_n_reg;
   assign dcd_n_o = dcd_n_reg;
   assign ri_n_o = ri_n_reg;
   assign pullup_en_o = pullup_reg;
   assign tx_grant_o = grant_reg;
   assign port_en_o = port_en_reg;
   assign active_mode_o = active_reg;
   assign connect_o = connect_reg;

   // Checks
   rxd_idle_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !tx_char_active_i |=> rxd_o)
      else $error("data output not idle high");
   cts_noflow_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (!hw_flow && !mux_on) |=> !cts_n_o)
      else $error("clear-to-send left ON state without flow control");
   cts_mux_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      mux_on |=> (cts_n_o == !port_en_o))
      else $error("clear-to-send not tracking power state in mux mode");
   tx_halt_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (hw_flow && rts_n_i) |=> !tx_grant_o)
      else $error("transmit still granted with request-to-send OFF");
   wake_delay_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      wake_tmr.load |=> port_en_o && !wake_done_reg)
      else $error("wake-up did not enable port or skipped delay");
   rts_sleep_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (rts_mode && rts_n_i) [*2] |-> !port_en_o)
      else $error("port enabled while request-to-send OFF");
   dsr_fixed_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !dsr_opt |=> !dsr_n_o)
      else $error("data-set-ready not held ON");
   dsr_mode_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      dsr_opt |=> (dsr_n_o == !$past(ctl_reg[CTL_DATA_MODE])))
      else $error("data-set-ready not following data mode");
   dcd_fixed_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !dcd_opt |=> !dcd_n_o)
      else $error("carrier-detect not held ON");
   connect_order_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      connect_o |-> !dcd_n_o && $past(!dcd_n_o))
      else $error("connect reported before carrier-detect");
   sms_ring_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      sms_trig |-> ##2 !ri_n_o)
      else $error("message did not raise ring indicator");
   psave_guard_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (psave == PSAVE_RTS) |-> !hw_flow)
      else $error("RTS power saving with flow control enabled");
endmodule

/* host_dte.sv */
// Purpose: Host terminal model on the far side of the handshake lines.
// Assumes: Device pulls its inputs up once pullup_en_i is high.
// Notes:   Released lines without pull-up toggle so no stale level passes.
`timescale 1ns/1ps
module host_dte (
   // Clock
   input wire logic clk_i,
   // Bench control
   input wire logic drive_i,
   input wire logic rts_on_i,
   input wire logic dtr_on_i,
   input wire logic txd_bit_i,
   // Device side
   input wire logic pullup_en_i,
   input wire logic rxd_i,
   output logic rts_n_o,
   output logic dtr_n_o,
   output logic txd_o,
   output int rx_starts_o
);
   logic tog = 1'b0;
   logic rxd_q = 1'b1;
   logic idle_lvl;
   int hold = 0;
   initial rx_starts_o = 0;
   // Released lines go to the pull-up level, else to a changing level
   assign idle_lvl = pullup_en_i ? 1'b1 : tog;
   assign rts_n_o = drive_i ? ~rts_on_i : idle_lvl;
   assign dtr_n_o = drive_i ? ~dtr_on_i : idle_lvl;
   assign txd_o = drive_i ? txd_bit_i : idle_lvl;
   // Host still takes characters after dropping its request; count start bits
   // Falling edges inside a frame are data bits, so the rest of it is skipped
   always @(posedge clk_i) begin
      tog <= ~tog;
      rxd_q <= rxd_i;
      if (hold != 0) begin
         hold <= hold - 1;
      end else if (rxd_q && !rxd_i) begin
         hold <= 9;
         if (rts_n_o) begin
            rx_starts_o <= rx_starts_o + 1;
         end
      end
   end
endmodule

/* tb.sv */
// Purpose: Self-checking bench for the modem handshake line controller.
// Assumes: Short millisecond base so ring periods stay in a short run.
// Notes:   Outputs are sampled on the falling edge, inputs move on the rising.
`timescale 1ns/1ps
module tb;
   import modem_lines_pkg::*;
   localparam int unsigned CPM = 4;
   logic clk_i = 1'b0, arst_n_i = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata_o, rd;
   logic pready_o, pslverr_o, er, rxd_o, cts_n_o, dsr_n_o, dcd_n_o, ri_n_o;
   logic pullup_en_o, tx_grant_o, port_en_o, active_mode_o, connect_o;
   logic rts_n, dtr_n, txd, tx_active, tx_bit, exp_rxd, grant_s;
   logic drive = 1'b0, rts_on = 1'b1, want_tx = 1'b0, rnd_bit = 1'b1;
   logic [7:0] bad_a [3];
   int fr_cnt = 0, starts, s0, n, err_count = 0, checks_done = 0;
   modem_lines #(.CYCLES_PER_MS(CPM)) u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .txd_i(txd), .rts_n_i(rts_n), .dtr_n_i(dtr_n),
      .rxd_o(rxd_o), .cts_n_o(cts_n_o), .dsr_n_o(dsr_n_o), .dcd_n_o(dcd_n_o),
      .ri_n_o(ri_n_o), .pullup_en_o(pullup_en_o), .tx_char_active_i(tx_active),
      .tx_bit_i(tx_bit), .tx_grant_o(tx_grant_o), .port_en_o(port_en_o),
      .active_mode_o(active_mode_o), .connect_o(connect_o));
   host_dte u_host (.clk_i(clk_i), .drive_i(drive), .rts_on_i(rts_on),
      .dtr_on_i(1'b0), .txd_bit_i(1'b1), .pullup_en_i(pullup_en_o), .rxd_i(rxd_o),
      .rts_n_o(rts_n), .dtr_n_o(dtr_n), .txd_o(txd), .rx_starts_o(starts));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // Framer: 10-cycle characters, started only on a granted cycle
   always @(negedge clk_i) grant_s = tx_grant_o;
   always @(posedge clk_i) begin
      rnd_bit <= $urandom;
      if (fr_cnt != 0) fr_cnt <= fr_cnt - 1;
      else if (want_tx && grant_s === 1'b1) fr_cnt <= 10;
   end
   assign tx_active = fr_cnt != 0;
   assign tx_bit = (fr_cnt == 10) ? 1'b0 : ((fr_cnt == 1) ? 1'b1 : rnd_bit);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(negedge clk_i);
         k++;
      end while (pready_o !== 1'b1 && k < 50);
      chk(k < 50, 1'b1);
      rd = prdata_o;
      er = pslverr_o;
      @(posedge clk_i);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk(er, 1'b0);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   // Wait, then compare {cts, dsr, dcd, ri}
   task automatic lines(input int k, input logic [3:0] e);
      cyc(k);
      @(negedge clk_i);
      chk({cts_n_o, dsr_n_o, dcd_n_o, ri_n_o}, e);
   endtask
   task automatic rst();
      arst_n_i <= 1'b0;
      cyc(20);
      @(negedge clk_i);
      chk({rxd_o, cts_n_o, dsr_n_o, dcd_n_o, ri_n_o}, 5'b10111);
      @(posedge clk_i);
      arst_n_i <= 1'b1;
   endtask
   task stop_test();
      $display("Checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #1000000;
      err_count++;
      stop_test();
   end
   initial begin
      void'($urandom(32'h3065532b));
      bad_a = '{8'h10, STATUS_ADDR, CONFIG_ADDR};
      rst();
      // Lines float until the pull-up is on, so let the samples settle first
      cyc(2);
      chk(pullup_en_o, 1'b1);
      // Host lets go of its lines: pulled up, read as OFF and idle high
      rdc(STATUS_ADDR, 32'h806, 32'h800);
      drive <= 1'b1;
      rdc(CONFIG_ADDR, 32'hFFFFFFFF, 32'h07);
      rdc(CONTROL_ADDR, 32'hFFFFFFFF, 32'h20);
      rdc(EVENT_ADDR, 32'hFFFFFFFF, 32'h0);
      // Refused writes; saving mode 2 with flow control is among them
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, bad_a[k], 32'h21);
         chk(er, 1'b1);
      end
      rdc(CONFIG_ADDR, 32'hFF, 32'h07);
      wr(CONTROL_ADDR, 32'h00);
      lines(3, 4'b1111);
      wr(CONTROL_ADDR, 32'h20);
      lines(3, 4'b0111);
      // Each control cause in turn; data mode owns dsr, all four drive dcd
      for (int k = 0; k < 4; k++) begin
         wr(CONTROL_ADDR, 32'h20 | (32'h1 << k));
         lines(3, {1'b0, k != 0, 1'b0, 1'b1});
      end
      wr(CONFIG_ADDR, 32'h01);
      wr(CONTROL_ADDR, 32'h20);
      lines(3, 4'b0001);
      wr(CONFIG_ADDR, 32'h07);
      // Packet dial, then remote accept: dcd low before connect
      for (int k = 0; k < 2; k++) begin
         wr(EVENT_ADDR, 32'h1 << (k ? EV_ACCEPT : EV_DIAL_PKT));
         n = 0;
         do begin
            @(negedge clk_i);
            n++;
         end while (connect_o !== 1'b1 && n < 30);
         chk({connect_o, dcd_n_o, dsr_n_o}, 3'b100);
         wr(CONTROL_ADDR, 32'h20);
      end
      // Random characters, then the host drops its request mid-stream
      want_tx <= 1'b1;
      for (int i = 0; i < 300; i++) begin
         @(negedge clk_i);
         if (i > 0) chk(rxd_o, exp_rxd);
         exp_rxd = tx_active ? tx_bit : 1'b1;
         if (i == 150) begin
            @(posedge clk_i);
            rts_on <= 1'b0;
            s0 = starts;
         end
      end
      chk({starts - s0 <= 2, tx_grant_o}, 2'b10);
      rts_on <= 1'b1;
      cyc(3);
      chk(tx_grant_o, 1'b1);
      want_tx <= 1'b0;
      // Incoming call ring cadence, then an early answer
      wr(CONTROL_ADDR, 32'h30);
      lines(5, 4'b0110);
      lines(4010, 4'b0111);
      lines(16000, 4'b0110);
      wr(EVENT_ADDR, 32'h1 << EV_ANSWER);
      lines(4, 4'b0111);
      rdc(CONTROL_ADDR, 32'h10, 32'h0);
      // Request-driven power saving without flow control
      wr(CONFIG_ADDR, 32'h26);
      rts_on <= 1'b0;
      cyc(3);
      chk({port_en_o, cts_n_o}, 2'b00);
      rts_on <= 1'b1;
      cyc(2);
      chk({port_en_o, active_mode_o}, 2'b11);
      rdc(STATUS_ADDR, 32'h20, 32'h0);
      cyc(20 * CPM + 5);
      rdc(STATUS_ADDR, 32'h20, 32'h20);
      // Message pulses retrigger, a reset mid-pulse clears the timer
      wr(CONFIG_ADDR, 32'h0F);
      wr(EVENT_ADDR, 32'h1 << EV_SMS);
      lines(5, 4'b0110);
      cyc(2000);
      wr(EVENT_ADDR, 32'h1 << EV_SMS);
      lines(2500, 4'b0110);
      lines(1600, 4'b0111);
      wr(EVENT_ADDR, 32'h1 << EV_SMS);
      cyc(100);
      rst();
      lines(10, 4'b0111);
      rdc(CONFIG_ADDR, 32'hFF, 32'h07);
      stop_test();
   end
endmodule
